// file: command_relay_interlock_logic.sv
// Purpose: command distribution interlocks for telemetry, power and recorders
// Assumes: strobes and status come from logic on core_clk, except link release and tone/frame status
// Notes:   link release and tone/frame status are synchronised in two stages
`timescale 1ns/1ps
`default_nettype none
module command_relay_interlock_logic (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire relay_pkg::cmd_t   cmd,
    input  wire relay_pkg::status_t status,
    input  wire logic              link_release_pulse,
    output var  relay_pkg::state_t state,
    output var  logic [2:0]        sco_hi1,
    output var  logic [2:0]        sco_hi2,
    output var  logic              time_code_reset,
    output var  logic              scanner_off_pulse
);

    // two-stage synchronisers for pin-level inputs
    logic       rel_s1;
    logic       rel_s2;
    logic       rel_s3;
    logic [3:0] st_s1;
    logic [3:0] st_s2;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rel_s1 <= 1'b0;
            rel_s2 <= 1'b0;
            rel_s3 <= 1'b0;
            st_s1  <= 4'h0;
            st_s2  <= 4'h0;
        end else begin
            rel_s1 <= link_release_pulse;
            rel_s2 <= rel_s1;
            rel_s3 <= rel_s2;
            st_s1  <= {status.tone1, status.tone2, status.frame1, status.frame2};
            st_s2  <= st_s1;
        end
    end

    // one pulse per release edge
    wire logic rel_now = rel_s2 & ~rel_s3;
    wire logic tone1   = st_s2[3];
    wire logic tone2   = st_s2[2];
    wire logic frame1  = st_s2[1];
    wire logic frame2  = st_s2[0];

    // exclusive selection latches
    logic beacon1;
    logic beacon2;
    logic timing1;
    logic timing2;
    logic seq1;
    logic seq2;
    logic cam1;
    logic cam2;
    logic rec1;
    logic rec2;
    logic sb1;
    logic sb2;
    logic mx1;
    logic mx2;

    select_pair #(.RESET_A(relay_pkg::RST_OFF)) u_beacon (
        .core_clk (core_clk), .rst (rst),
        .pick_a (cmd.beacon1_sel), .pick_b (cmd.beacon2_sel), .pick_none (cmd.beacon_none),
        .sel_a (beacon1), .sel_b (beacon2));
    select_pair #(.RESET_A(relay_pkg::RST_TIMING_A)) u_timing (
        .core_clk (core_clk), .rst (rst),
        .pick_a (cmd.timing1_sel), .pick_b (cmd.timing2_sel), .pick_none (1'b0),
        .sel_a (timing1), .sel_b (timing2));
    select_pair #(.RESET_A(relay_pkg::RST_OFF)) u_seq (
        .core_clk (core_clk), .rst (rst),
        .pick_a (cmd.seq1_sel), .pick_b (cmd.seq2_sel), .pick_none (cmd.seq_none),
        .sel_a (seq1), .sel_b (seq2));
    select_pair #(.RESET_A(relay_pkg::RST_OFF)) u_cam (
        .core_clk (core_clk), .rst (rst),
        .pick_a (cmd.cam1_sel), .pick_b (cmd.cam2_sel), .pick_none (cmd.cam_none),
        .sel_a (cam1), .sel_b (cam2));
    select_pair #(.RESET_A(relay_pkg::RST_OFF)) u_rec (
        .core_clk (core_clk), .rst (rst),
        .pick_a (cmd.rec1_sel), .pick_b (cmd.rec2_sel), .pick_none (cmd.rec_none),
        .sel_a (rec1), .sel_b (rec2));
    select_pair #(.RESET_A(relay_pkg::RST_OFF)) u_sband (
        .core_clk (core_clk), .rst (rst),
        .pick_a (cmd.sband1_sel), .pick_b (cmd.sband2_sel), .pick_none (1'b0),
        .sel_a (sb1), .sel_b (sb2));
    select_pair #(.RESET_A(relay_pkg::RST_OFF)) u_mux (
        .core_clk (core_clk), .rst (rst),
        .pick_a (cmd.mux1_sel), .pick_b (cmd.mux2_sel), .pick_none (1'b0),
        .sel_a (mx1), .sel_b (mx2));

    // latched control state
    logic       comm1;
    logic       comm2;
    logic       comm_auto;
    logic       comm_hooked;
    logic       acq_mode;
    logic       converter;
    logic       tied;
    logic       radiometer;
    logic       rad_cal;
    logic       sband_on;
    logic       playback;
    logic       advance;
    logic [2:0] lf_source;
    logic       tone1_frame;
    logic       tone2_frame;

    // emergency tone acceptance gated by beacon power
    wire logic tone1_ok = tone1 & beacon1;
    wire logic tone2_ok = tone2 & beacon2;
    // tone held since frame start overrides automatic turn-off
    wire logic kill1    = frame1 & ~(tone1_ok & tone1_frame);
    wire logic kill2    = frame2 & ~(tone2_ok & tone2_frame);
    wire logic comm_kill = cmd.beacon_none | kill1 | kill2;

    wire logic next_comm1 = (cmd.comm1_on | tone1_ok) | (comm1 & ~comm_kill);
    wire logic next_comm2 = (cmd.comm2_on | tone2_ok) | (comm2 & ~comm_kill);
    wire logic next_auto  = (cmd.comm_auto | tone1_ok | tone2_ok) ? 1'b1 :
                            (cmd.comm_manual ? 1'b0 : comm_auto);
    // outputs rehooked by any commutator turn-on, unhooked by release
    wire logic next_hooked = (cmd.comm1_on | cmd.comm2_on | tone1_ok | tone2_ok) ? 1'b1 :
                             (rel_now ? 1'b0 : comm_hooked);

    // converter and radiometer interlock
    wire logic next_conv  = (cmd.conv_on | cmd.rad_on) ? 1'b1 :
                            (cmd.conv_off ? 1'b0 : converter);
    wire logic next_tied  = (cmd.conv_off | cmd.digital_disable) ? 1'b1 :
                            ((cmd.conv_on | cmd.rad_on) ? 1'b0 : tied);
    wire logic next_rad   = cmd.conv_off ? 1'b0 :
                            (cmd.rad_on ? 1'b1 : (cmd.rad_off ? 1'b0 : radiometer));
    wire logic next_cal   = cmd.rad_on ? 1'b0 :
                            (cmd.rad_cal ? 1'b1 : rad_cal);

    // transmitter power; release wins over on
    wire logic next_sband = (rel_now | cmd.sband_off) ? 1'b0 :
                            (cmd.sband_on ? 1'b1 : sband_on);
    wire logic sband_live = sband_on & (sb1 | sb2);

    // playback enabling conditions and terminating events
    wire logic play_ok    = (rec1 | rec2) & sband_live & ~status.end_of_tape;
    wire logic rec_change = cmd.rec1_sel | cmd.rec2_sel | cmd.rec_none;
    wire logic play_end   = cmd.rec_stop | rel_now | status.end_of_tape | rec_change |
                            cmd.sband_off;
    wire logic next_play  = play_end ? 1'b0 :
                            ((cmd.rec_play | playback) & play_ok);
    wire logic next_adv   = (cmd.rec_stop | rel_now) ? 1'b0 :
                            (cmd.rec_advance ? 1'b1 : advance);

    // low-frequency chain source, last command wins
    wire logic [2:0] next_lf =
        cmd.lf_pitch1   ? relay_pkg::LF_PITCH1   :
        cmd.lf_pitch2   ? relay_pkg::LF_PITCH2   :
        cmd.lf_rollidx1 ? relay_pkg::LF_ROLLIDX1 :
        cmd.lf_rollidx2 ? relay_pkg::LF_ROLLIDX2 :
        cmd.lf_time     ? relay_pkg::LF_TIME     :
        cmd.lf_roll1    ? relay_pkg::LF_ROLL1    :
        cmd.lf_roll2    ? relay_pkg::LF_ROLL2    : lf_source;

    wire logic next_acq = cmd.tlm_acq ? 1'b1 : (cmd.tlm_oper ? 1'b0 : acq_mode);

    // priority trees for the higher subcarrier of each beacon
    wire logic       verify  = status.verify_prog | status.verify_dec1 | status.verify_dec2;
    wire logic       c1_out  = comm1 & comm_hooked;
    wire logic       c2_out  = comm2 & comm_hooked;
    wire logic [2:0] sensor  = acq_mode ? relay_pkg::SRC_SUN : relay_pkg::SRC_PROTON;
    wire logic [2:0] ver_src1 = (status.verify_dec1 | status.verify_prog) ?
                                relay_pkg::SRC_VERIFY1 : relay_pkg::SRC_VERIFY2;
    wire logic [2:0] next_sco1 = c1_out ? relay_pkg::SRC_COMM1 :
                                 c2_out ? relay_pkg::SRC_COMM2 :
                                 verify ? ver_src1 : sensor;
    wire logic [2:0] next_sco2 = c2_out ? relay_pkg::SRC_COMM2 :
                                 c1_out ? relay_pkg::SRC_COMM1 :
                                 verify ? relay_pkg::SRC_VERIFY2 : sensor;

    // telemetry and commutator latches
    always_ff @(posedge core_clk) begin
        if (rst) begin
            comm1       <= relay_pkg::RST_OFF;
            comm2       <= relay_pkg::RST_OFF;
            comm_auto   <= relay_pkg::RST_OFF;
            comm_hooked <= relay_pkg::RST_OFF;
            acq_mode    <= relay_pkg::RST_OFF;
            lf_source   <= relay_pkg::RST_LF;
            tone1_frame <= relay_pkg::RST_OFF;
            tone2_frame <= relay_pkg::RST_OFF;
        end else begin
            comm1       <= next_comm1;
            comm2       <= next_comm2;
            comm_auto   <= next_auto;
            comm_hooked <= next_hooked;
            acq_mode    <= next_acq;
            lf_source   <= next_lf;
            // tone seen continuously since last frame pulse
            tone1_frame <= frame1 ? tone1_ok : (tone1_frame & tone1_ok);
            tone2_frame <= frame2 ? tone2_ok : (tone2_frame & tone2_ok);
        end
    end

    // power, recorder and transmitter latches
    always_ff @(posedge core_clk) begin
        if (rst) begin
            converter  <= relay_pkg::RST_OFF;
            tied       <= relay_pkg::RST_OFF;
            radiometer <= relay_pkg::RST_OFF;
            rad_cal    <= relay_pkg::RST_OFF;
            sband_on   <= relay_pkg::RST_OFF;
            playback   <= relay_pkg::RST_OFF;
            advance    <= relay_pkg::RST_OFF;
        end else begin
            converter  <= next_conv;
            tied       <= next_tied;
            radiometer <= next_rad;
            rad_cal    <= next_cal;
            sband_on   <= next_sband;
            playback   <= next_play;
            advance    <= next_adv;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state             <= '0;
            sco_hi1           <= relay_pkg::SRC_NONE;
            sco_hi2           <= relay_pkg::SRC_NONE;
            time_code_reset   <= 1'b0;
            scanner_off_pulse <= 1'b0;
        end else begin
            state.beacon1         <= beacon1;
            state.beacon2         <= beacon2;
            state.comm1           <= comm1;
            state.comm2           <= comm2;
            state.comm_auto       <= comm_auto;
            state.hk_bus          <= comm1 | comm2;
            state.digital_bus     <= converter | (tied & (comm1 | comm2));
            state.digital_tied    <= tied;
            state.sun_sensor      <= acq_mode;
            state.converter       <= converter;
            state.tape_recorder   <= converter;
            state.radiometer      <= radiometer & converter;
            state.rad_cal         <= rad_cal;
            state.timing1         <= timing1;
            state.timing2         <= timing2;
            state.seq1            <= seq1;
            state.seq2            <= seq2;
            state.cam1            <= cam1;
            state.cam2            <= cam2;
            state.rec1            <= rec1;
            state.rec2            <= rec2;
            state.playback        <= playback;
            state.play_track2     <= cam2;
            state.advance         <= advance | status.prog_advance;
            state.sband1_sel      <= sb1;
            state.sband2_sel      <= sb2;
            state.sband1_pwr      <= sband_on & sb1;
            state.sband2_pwr      <= sband_on & sb2;
            state.mux1_pwr        <= sband_live & mx1;
            state.mux2_pwr        <= sband_live & mx2;
            state.playback_enable <= sband_live;
            state.direct_picture  <= (cam1 | cam2) & (rec1 | rec2) & sband_live;
            state.lf_source       <= lf_source;
            sco_hi1               <= next_sco1;
            sco_hi2               <= next_sco2;
            time_code_reset       <= cmd.timing1_sel | cmd.timing2_sel;
            scanner_off_pulse     <= cmd.seq_none;
        end
    end

endmodule : command_relay_interlock_logic
`default_nettype wire

// file: relay_pkg.sv
// Purpose: shared types and constants for the command relay interlock logic
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   command strobes travel as one packed struct
package relay_pkg;

    // telemetry source codes driven onto each subcarrier oscillator
    localparam logic [2:0] SRC_NONE     = 3'h0;
    localparam logic [2:0] SRC_COMM1    = 3'h1;
    localparam logic [2:0] SRC_COMM2    = 3'h2;
    localparam logic [2:0] SRC_VERIFY1  = 3'h3;
    localparam logic [2:0] SRC_VERIFY2  = 3'h4;
    localparam logic [2:0] SRC_SUN      = 3'h5;
    localparam logic [2:0] SRC_PROTON   = 3'h6;

    // low-frequency chain selections
    localparam logic [2:0] LF_OPEN      = 3'h0;
    localparam logic [2:0] LF_ROLL1     = 3'h1;
    localparam logic [2:0] LF_ROLL2     = 3'h2;
    localparam logic [2:0] LF_ROLLIDX1  = 3'h3;
    localparam logic [2:0] LF_ROLLIDX2  = 3'h4;
    localparam logic [2:0] LF_TIME      = 3'h5;
    localparam logic [2:0] LF_PITCH1    = 3'h6;
    localparam logic [2:0] LF_PITCH2    = 3'h7;

    // reset values of latched states
    localparam logic       RST_OFF      = 1'b0;
    localparam logic       RST_TIMING_A = 1'b1;   // side one of the timing unit powered
    localparam logic [2:0] RST_LF       = 3'h0;

    // one-cycle command strobes from either decoder
    typedef struct packed {
        logic beacon1_sel;
        logic beacon2_sel;
        logic beacon_none;
        logic comm1_on;
        logic comm2_on;
        logic comm_auto;
        logic comm_manual;
        logic tlm_oper;
        logic tlm_acq;
        logic lf_pitch1;
        logic lf_pitch2;
        logic lf_rollidx1;
        logic lf_rollidx2;
        logic lf_time;
        logic lf_roll1;
        logic lf_roll2;
        logic conv_on;
        logic conv_off;
        logic digital_disable;
        logic rad_on;
        logic rad_off;
        logic rad_cal;
        logic timing1_sel;
        logic timing2_sel;
        logic seq1_sel;
        logic seq2_sel;
        logic seq_none;
        logic cam1_sel;
        logic cam2_sel;
        logic cam_none;
        logic rec1_sel;
        logic rec2_sel;
        logic rec_none;
        logic rec_play;
        logic rec_advance;
        logic rec_stop;
        logic sband1_sel;
        logic sband2_sel;
        logic sband_on;
        logic sband_off;
        logic mux1_sel;
        logic mux2_sel;
    } cmd_t;

    // status inputs from programmer, commutators and recorders
    typedef struct packed {
        logic tone1;
        logic tone2;
        logic frame1;
        logic frame2;
        logic verify_dec1;
        logic verify_dec2;
        logic verify_prog;
        logic end_of_tape;
        logic prog_advance;
    } status_t;

    // latched power and selection outputs
    typedef struct packed {
        logic       beacon1;
        logic       beacon2;
        logic       comm1;
        logic       comm2;
        logic       comm_auto;
        logic       hk_bus;
        logic       digital_bus;
        logic       digital_tied;
        logic       sun_sensor;
        logic       converter;
        logic       tape_recorder;
        logic       radiometer;
        logic       rad_cal;
        logic       timing1;
        logic       timing2;
        logic       seq1;
        logic       seq2;
        logic       cam1;
        logic       cam2;
        logic       rec1;
        logic       rec2;
        logic       playback;
        logic       play_track2;
        logic       advance;
        logic       sband1_sel;
        logic       sband2_sel;
        logic       sband1_pwr;
        logic       sband2_pwr;
        logic       mux1_pwr;
        logic       mux2_pwr;
        logic       direct_picture;
        logic       playback_enable;
        logic [2:0] lf_source;
    } state_t;

endpackage : relay_pkg

// file: select_pair.sv
// Purpose: mutually exclusive two-way selection latch
// Assumes: strobes are single-cycle; reset value set by parameter
// Notes:   one side at most, or exactly one when no neither strobe is wired and RESET_A is set
`timescale 1ns/1ps
`default_nettype none
module select_pair #(
    parameter logic RESET_A = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pick_a,
    input  wire logic pick_b,
    input  wire logic pick_none,
    output var  logic sel_a,
    output var  logic sel_b
);

    // later strobe in priority order: none beats b beats a
    wire logic next_a = pick_none ? 1'b0 : (pick_b ? 1'b0 : (pick_a ? 1'b1 : sel_a));
    wire logic next_b = pick_none ? 1'b0 : (pick_b ? 1'b1 : (pick_a ? 1'b0 : sel_b));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_a <= RESET_A;
            sel_b <= 1'b0;
        end else begin
            sel_a <= next_a;
            sel_b <= next_b;
        end
    end

endmodule : select_pair
`default_nettype wire

// file: decoder_model.sv
// Purpose: stand-in for the two command decoders and the programmer
// Assumes: bench asks for strobes one cycle ahead on core_clk
// Notes:   release pulse stays up three cycles so the two-flop sync sees it
`timescale 1ns/1ps
`default_nettype none
module decoder_model (
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire relay_pkg::cmd_t req,
    input  wire logic            fire,
    input  wire logic            dec_power,
    output var  relay_pkg::cmd_t cmd,
    output var  logic            link_release_pulse
);
    logic       pw_q;
    logic [1:0] hold;

    // one strobe per request, never held; release once per power drop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd  <= '0;
            pw_q <= 1'b1;
            hold <= 2'h0;
        end else begin
            cmd  <= fire ? req : '0;
            pw_q <= dec_power;
            hold <= (pw_q && !dec_power) ? 2'h3 : hold - 2'(hold != 2'h0);
        end
    end

    assign link_release_pulse = (hold != 2'h0);
endmodule : decoder_model
`default_nettype wire

// file: relay_checker_sva.sv
// Purpose: port-level interlock checks for the command relay logic
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the design
`timescale 1ns/1ps
`default_nettype none
module relay_checker (
    input wire logic               core_clk,
    input wire logic               rst,
    input wire relay_pkg::cmd_t    cmd,
    input wire relay_pkg::status_t status,
    input wire logic               link_release_pulse,
    input wire relay_pkg::state_t  state,
    input wire logic [2:0]         sco_hi1,
    input wire logic [2:0]         sco_hi2,
    input wire logic               time_code_reset,
    input wire logic               scanner_off_pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // command and release steps
    sequence cam1_pick_s;
        cmd.cam1_sel && !cmd.cam2_sel && !cmd.cam_none;
    endsequence
    sequence release_s;
        !link_release_pulse ##1 link_release_pulse [*2];
    endsequence

    cam_pick_a: assert property (cam1_pick_s |-> ##2 state.cam1 && !state.cam2)
        else $error("camera one select not latched");
    cam_excl_a: assert property (!(state.cam1 && state.cam2))
        else $error("both cameras powered");
    timing_one_a: assert property (!$past(rst) && !$past(rst, 2) |-> state.timing1 != state.timing2)
        else $error("timing unit sides not exclusive");
    time_code_a: assert property (cmd.timing1_sel || cmd.timing2_sel |-> ##[1:2] time_code_reset)
        else $error("time code reset missing");
    scanner_off_a: assert property (cmd.seq_none |-> ##[1:2] scanner_off_pulse)
        else $error("scanner turn-off pulse missing");
    seq_excl_a: assert property (!(state.seq1 && state.seq2))
        else $error("both sequencers selected");
    rad_conv_a: assert property (state.radiometer |-> state.converter)
        else $error("radiometer on without converter");
    sun_power_a: assert property (cmd.tlm_acq && !cmd.tlm_oper |-> ##2 state.sun_sensor)
        else $error("sun sensor not powered");
    play_gate_a: assert property (state.playback |-> (state.rec1 || state.rec2)
        && (state.sband1_pwr || state.sband2_pwr))
        else $error("playback without recorder or transmitter");
    release_end_a: assert property (release_s |-> ##[2:5] !state.playback && !state.sband1_pwr
        && !state.sband2_pwr && !state.mux1_pwr && !state.mux2_pwr)
        else $error("release did not end playback and transmitter");
    direct_pic_a: assert property (((state.cam1 || state.cam2) && (state.rec1 || state.rec2)
        && (state.sband1_pwr || state.sband2_pwr)) [*2] |-> state.direct_picture)
        else $error("direct picture enable missing");
endmodule : relay_checker

bind command_relay_interlock_logic relay_checker u_relay_checker (.core_clk(core_clk), .rst(rst),
    .cmd(cmd), .status(status), .link_release_pulse(link_release_pulse), .state(state),
    .sco_hi1(sco_hi1), .sco_hi2(sco_hi2), .time_code_reset(time_code_reset),
    .scanner_off_pulse(scanner_off_pulse));
`default_nettype wire

// file: command_relay_interlock_logic_test.sv
// Purpose: self-checking bench for the command relay interlock logic
// Assumes: decoder model makes strobes; status levels driven here
// Notes:   table rows first, then tone, release and playback cases
`timescale 1ns/1ps
`default_nettype none
module command_relay_interlock_logic_test;
    typedef struct {relay_pkg::cmd_t c; relay_pkg::state_t m; relay_pkg::state_t e;} row_t;
    logic               core_clk, rst, fire, dec_power, link_release_pulse;
    logic               time_code_reset, scanner_off_pulse;
    logic [2:0]         sco_hi1, sco_hi2;
    relay_pkg::cmd_t    req, cmd;
    relay_pkg::status_t status;
    relay_pkg::state_t  state;
    int                 n_errors, check_count, cycles;
    row_t               rows[13];
    relay_pkg::cmd_t    lf_c[7];
    logic [2:0]         lf_e[7];

    decoder_model u_dec (.core_clk(core_clk), .rst(rst), .req(req), .fire(fire),
        .dec_power(dec_power), .cmd(cmd), .link_release_pulse(link_release_pulse));
    command_relay_interlock_logic dut (.core_clk(core_clk), .rst(rst), .cmd(cmd), .status(status),
        .link_release_pulse(link_release_pulse), .state(state), .sco_hi1(sco_hi1),
        .sco_hi2(sco_hi2), .time_code_reset(time_code_reset), .scanner_off_pulse(scanner_off_pulse));

    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test;
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    // one strobe through the decoder model, then let it reach the outputs
    task automatic send(input relay_pkg::cmd_t c);
        req = c;
        fire = 1'b1;
        wait_cyc(1);
        fire = 1'b0;
        req = '0;
        wait_cyc(4);
    endtask : send

    task automatic drop_power;
        dec_power = 1'b0;
        wait_cyc(10);
        dec_power = 1'b1;
        wait_cyc(2);
    endtask : drop_power

    initial begin
        rst = 1'b1; fire = 1'b0; dec_power = 1'b1; req = '0; status = '0;
        rows = '{'{'{tlm_acq:1, default:0}, '{sun_sensor:1, default:0}, '{sun_sensor:1, default:0}},
            '{'{tlm_oper:1, default:0}, '{sun_sensor:1, default:0}, '{default:0}},
            '{'{cam1_sel:1, default:0}, '{cam1:1, cam2:1, default:0}, '{cam1:1, default:0}},
            '{'{cam2_sel:1, default:0}, '{cam1:1, cam2:1, default:0}, '{cam2:1, default:0}},
            '{'{cam_none:1, default:0}, '{cam1:1, cam2:1, default:0}, '{default:0}},
            '{'{conv_on:1, default:0}, '{converter:1, tape_recorder:1, digital_bus:1, default:0},
                '{converter:1, tape_recorder:1, digital_bus:1, default:0}},
            '{'{rad_cal:1, default:0}, '{rad_cal:1, default:0}, '{rad_cal:1, default:0}},
            '{'{rad_on:1, default:0}, '{radiometer:1, rad_cal:1, converter:1, default:0},
                '{radiometer:1, converter:1, default:0}},
            '{'{conv_off:1, default:0}, '{converter:1, radiometer:1, tape_recorder:1,
                digital_tied:1, default:0}, '{digital_tied:1, default:0}},
            '{'{timing2_sel:1, default:0}, '{timing1:1, timing2:1, default:0}, '{timing2:1, default:0}},
            '{'{timing1_sel:1, default:0}, '{timing1:1, timing2:1, default:0}, '{timing1:1, default:0}},
            '{'{seq1_sel:1, default:0}, '{seq1:1, seq2:1, default:0}, '{seq1:1, default:0}},
            '{'{seq_none:1, default:0}, '{seq1:1, seq2:1, default:0}, '{default:0}}};
        lf_c = '{'{lf_pitch1:1, default:0}, '{lf_pitch2:1, default:0}, '{lf_rollidx1:1, default:0},
            '{lf_rollidx2:1, default:0}, '{lf_time:1, default:0}, '{lf_roll1:1, default:0},
            '{lf_roll2:1, default:0}};
        lf_e = '{relay_pkg::LF_PITCH1, relay_pkg::LF_PITCH2, relay_pkg::LF_ROLLIDX1,
            relay_pkg::LF_ROLLIDX2, relay_pkg::LF_TIME, relay_pkg::LF_ROLL1, relay_pkg::LF_ROLL2};
        wait_cyc(6);
        chk("reset state", 64'h0, 64'(state));
        chk("reset sco", 64'(relay_pkg::SRC_NONE), 64'(sco_hi1));
        rst = 1'b0;
        wait_cyc(2);
        chk("timing side one", 64'h1, 64'(state.timing1));
        // table of single strobes
        foreach (rows[i]) begin
            send(rows[i].c);
            chk($sformatf("row %0d", i), 64'(rows[i].e), 64'(state & rows[i].m));
        end
        foreach (lf_c[i]) begin
            send(lf_c[i]);
            chk("lf source", 64'(lf_e[i]), 64'(state.lf_source));
        end
        // tones gated by beacon power, release, verification, frame end
        status.tone1 = 1'b1;
        wait_cyc(8);
        chk("tone without beacon", 64'h0, 64'(state.comm1));
        status.tone1 = 1'b0;
        send('{beacon1_sel:1, default:0});
        status.tone1 = 1'b1;
        status.tone2 = 1'b1;
        wait_cyc(8);
        chk("tone accepted", 64'hb, 64'({state.comm1, state.comm2, state.comm_auto, state.hk_bus}));
        chk("sco commutator", 64'({relay_pkg::SRC_COMM1, relay_pkg::SRC_COMM1}),
            64'({sco_hi1, sco_hi2}));
        status.tone1 = 1'b0;
        status.tone2 = 1'b0;
        drop_power();
        wait_cyc(4);
        chk("release keeps power", 64'h3, 64'({state.comm1, state.hk_bus}));
        status.verify_dec1 = 1'b1;
        wait_cyc(4);
        chk("sco verify", 64'({relay_pkg::SRC_VERIFY1, relay_pkg::SRC_VERIFY2}),
            64'({sco_hi1, sco_hi2}));
        status.verify_dec1 = 1'b0;
        status.frame1 = 1'b1;
        wait_cyc(3);
        status.frame1 = 1'b0;
        wait_cyc(6);
        chk("frame turn-off", 64'h0, 64'({state.comm1, state.hk_bus}));
        send('{beacon2_sel:1, comm2_on:1, default:0});
        chk("commutator two", 64'h3, 64'({state.comm2, state.hk_bus}));
        send('{beacon_none:1, default:0});
        chk("no beacon turn-off", 64'h0, 64'({state.comm2, state.hk_bus, state.beacon2}));
        // playback interlocks
        send('{rec1_sel:1, cam1_sel:1, mux1_sel:1, default:0});
        send('{rec_play:1, default:0});
        chk("play refused", 64'h0, 64'(state.playback));
        send('{sband1_sel:1, default:0});
        send('{sband_on:1, default:0});
        chk("transmitter on", 64'hf, 64'({state.sband1_pwr, state.mux1_pwr, state.playback_enable,
            state.direct_picture}));
        send('{rec_play:1, default:0});
        send('{cam2_sel:1, default:0});
        chk("camera change", 64'h3, 64'({state.playback, state.play_track2}));
        send('{rec2_sel:1, default:0});
        chk("recorder change", 64'h0, 64'(state.playback));
        send('{rec_play:1, rec_advance:1, default:0});
        chk("play and advance", 64'h3, 64'({state.playback, state.advance}));
        send('{rec_stop:1, default:0});
        chk("stop", 64'h0, 64'({state.playback, state.advance}));
        send('{rec_play:1, default:0});
        status.end_of_tape = 1'b1;
        wait_cyc(4);
        chk("end of tape", 64'h0, 64'(state.playback));
        status.end_of_tape = 1'b0;
        send('{rec_play:1, rec_advance:1, default:0});
        drop_power();
        wait_cyc(4);
        chk("release ends", 64'h0, 64'({state.playback, state.advance, state.sband1_pwr,
            state.mux1_pwr, state.direct_picture}));
        finish_test();
    end
endmodule : command_relay_interlock_logic_test
`default_nettype wire
